// >>> core/manual_fire_softkey_io_pkg.sv
// Constants, register map and field layout of the trigger pin controller
// Functional notes
// - Configured input action runs only after a recognised high pulse on the trigger input.
// - Pulse must stay high the minimum width: zero means 5 ms, else 1-60 ms.
// - Action none ignores pin pulses; remote trigger commands still work.
// - Action output drives output enable to the configured status.
// - Action settings copies stored user voltage and frequency to active settings.
// - Action preset loads the preset slot chosen by index zero to nine.
// - Action transient issues a start request to the transient event generator.
// - Trigger configuration has no effect in simulation or sequence test modes.
// - Source none: no internal event fires the output pin; remote requests still do.
// - Source output: pin fires when output enable turns on or off.
// - Source settings: pin fires when active settings change.
// - Source preset: pin fires when a preset is loaded or saved.
// - Source all: pin fires on settings, preset or output state change.
// - Width 1 to 60 ms: pin high for exactly that width, then released; an event during the pulse restarts the count and lengthens it.
// - Width zero: pin held at configured level while source condition is true.
// - Output level setting ignored when output width is 1 to 60 ms.
// - Ten preset slots zero to nine, loadable, reporting load and save events.
package manual_fire_softkey_io_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
	localparam logic [5:0]  IN_WIDTH_DFLT = 6'h05;
	localparam logic [5:0]  WIDTH_MAX     = 6'h3c;

	// ****************************************************************
	// Register bus
	// ****************************************************************
	localparam int unsigned AW = 8;
	localparam int unsigned DW = 32;
	localparam int unsigned VW = 16;
	localparam logic [AW-1:0] REG_IN_CFG  = 8'h00;
	localparam logic [AW-1:0] REG_OUT_CFG = 8'h04;
	localparam logic [AW-1:0] REG_USER_V  = 8'h08;
	localparam logic [AW-1:0] REG_USER_F  = 8'h0c;
	localparam logic [AW-1:0] REG_OUT_CTL = 8'h10;
	localparam logic [AW-1:0] REG_ACT_V   = 8'h14;
	localparam logic [AW-1:0] REG_ACT_F   = 8'h18;
	localparam logic [AW-1:0] REG_MODE    = 8'h1c;
	localparam logic [AW-1:0] REG_CMD     = 8'h20;
	localparam logic [AW-1:0] REG_STATUS  = 8'h24;

	// ****************************************************************
	// Fields
	// ****************************************************************
	localparam int unsigned F_ACTION  = 0;
	localparam int unsigned F_WIDTH   = 3;
	localparam int unsigned F_STATUS  = 9;
	localparam int unsigned F_INDEX   = 10;
	localparam int unsigned F_LEVEL   = 9;
	localparam int unsigned F_MODE_SIM = 0;
	localparam int unsigned F_MODE_SEQ = 1;
	localparam int unsigned C_TRANS   = 0;
	localparam int unsigned C_OUTTRG  = 1;
	localparam int unsigned C_SAVE    = 2;
	localparam int unsigned C_LOAD    = 3;
	localparam int unsigned C_CLRCOND = 4;
	localparam int unsigned C_SLOT    = 8;

	// ****************************************************************
	// Codes and reset values
	// ****************************************************************
	localparam logic [2:0] ACT_NONE    = 3'h0;
	localparam logic [2:0] ACT_OUTPUT  = 3'h1;
	localparam logic [2:0] ACT_SETTING = 3'h2;
	localparam logic [2:0] ACT_PRESET  = 3'h3;
	localparam logic [2:0] ACT_TRANS   = 3'h4;
	localparam logic [2:0] SRC_NONE    = 3'h0;
	localparam logic [2:0] SRC_OUTPUT  = 3'h1;
	localparam logic [2:0] SRC_SETTING = 3'h2;
	localparam logic [2:0] SRC_PRESET  = 3'h3;
	localparam logic [2:0] SRC_ALL     = 3'h4;
	localparam int unsigned NSLOT      = 10;
	localparam logic [3:0] SLOT_LAST   = 4'h9;
	localparam logic [VW-1:0] V_RST    = 16'h0000;
	localparam logic [VW-1:0] F_RST    = 16'h0000;

	typedef enum logic [1:0] {Q_IDLE, Q_MEASURE, Q_WAIT_LOW} qual_e;
	typedef enum logic       {P_IDLE, P_PULSE} pulse_e;

endpackage : manual_fire_softkey_io_pkg

// >>> core/ms_tick_gen.sv
// Millisecond tick divider with synchronous restart
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
	parameter int unsigned CYCLES = 20000
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic clear_i,
	output logic      tick_o
);

	localparam int unsigned CW = $clog2(CYCLES);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} tick_s;

	tick_s st;
	tick_s next_st;

	// Restart loads one: the tick is registered, so every ms is exactly CYCLES long
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (clear_i) begin
			next_st.cnt = CW'(1);
		end else if (st.cnt == CW'(CYCLES - 1)) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

endmodule : ms_tick_gen
`default_nettype wire

// >>> core/manual_fire_softkey_io_ctrl.sv
// Trigger input qualification, trigger actions, preset slots and trigger output pin
`timescale 1ns/1ps
`default_nettype none
module manual_fire_softkey_io_ctrl #(
	parameter int unsigned MS_CYC = manual_fire_softkey_io_pkg::MS_CYCLES
) (
	input  wire logic                      REF_CLK_I,
	input  wire logic                      NRST_I,
	input  wire logic                      MANUAL_FIRE_SOFTKEY_IN_I,
	input  wire logic [manual_fire_softkey_io_pkg::AW-1:0] ADDR_I,
	input  wire logic [manual_fire_softkey_io_pkg::DW-1:0] WDATA_I,
	input  wire logic                      WR_I,
	input  wire logic                      RD_I,
	output logic      [manual_fire_softkey_io_pkg::DW-1:0] RDATA_O,
	output logic                           MANUAL_FIRE_SOFTKEY_OUT_O,
	output logic                           OUTPUT_EN_O,
	output logic      [manual_fire_softkey_io_pkg::VW-1:0] VOLT_O,
	output logic      [manual_fire_softkey_io_pkg::VW-1:0] FREQ_O,
	output logic                           TRANSIENT_START_O,
	output logic                           PRESET_LOAD_O,
	output logic                           PRESET_SAVE_O
);
	import manual_fire_softkey_io_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [1:0]              sync;
		qual_e                   qual;
		logic [5:0]              in_ms;
		pulse_e                  pst;
		logic [5:0]              out_ms;
		logic                    cond;
		logic [2:0]              action;
		logic [5:0]              in_width;
		logic                    status;
		logic [3:0]              index;
		logic [2:0]              source;
		logic [5:0]              out_width;
		logic                    level;
		logic [VW-1:0]           user_v;
		logic [VW-1:0]           user_f;
		logic                    out_en;
		logic [VW-1:0]           act_v;
		logic [VW-1:0]           act_f;
		logic                    sim;
		logic                    seq;
		logic [NSLOT-1:0][VW-1:0] pre_v;
		logic [NSLOT-1:0][VW-1:0] pre_f;
		logic                    pin;
		logic                    trans;
		logic                    load_ev;
		logic                    save_ev;
		logic [DW-1:0]           rdata;
	} ctrl_s;

	ctrl_s st;
	ctrl_s next_st;

	logic in_tick;
	logic out_tick;
	logic in_clear;
	logic out_clear;

	// One divider per pin, so input and output timing restart independently

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Widths above the range clamp to 60 ms instead of wrapping
	function automatic logic [5:0] clamp_width(input logic [5:0] w);
		clamp_width = (w > WIDTH_MAX) ? WIDTH_MAX : w;
	endfunction : clamp_width

	// Slot numbers above nine are ignored, never aliased
	function automatic logic slot_ok(input logic [3:0] s);
		slot_ok = (s <= SLOT_LAST);
	endfunction : slot_ok

	// ****************************************************************
	// Tick dividers
	// ****************************************************************
	ms_tick_gen #(
		.CYCLES (MS_CYC)
	) u_in_tick (
		.clk_i   (REF_CLK_I),
		.nrst_i  (NRST_I),
		.clear_i (in_clear),
		.tick_o  (in_tick)
	);

	ms_tick_gen #(
		.CYCLES (MS_CYC)
	) u_out_tick (
		.clk_i   (REF_CLK_I),
		.nrst_i  (NRST_I),
		.clear_i (out_clear),
		.tick_o  (out_tick)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic       test_mode;
		logic       fire;
		logic [5:0] in_target;
		logic [5:0] ow;
		logic       ev_out;
		logic       ev_set;
		logic       ev_pre;
		logic       activate;
		logic       wr_cmd;
		logic [3:0] cmd_slot;
		test_mode = 1'b0;
		fire = 1'b0;
		in_target = '0;
		ow = '0;
		ev_out = 1'b0;
		ev_set = 1'b0;
		ev_pre = 1'b0;
		activate = 1'b0;
		wr_cmd = 1'b0;
		cmd_slot = '0;
		next_st = st;
		next_st.trans = 1'b0;
		next_st.load_ev = 1'b0;
		next_st.save_ev = 1'b0;
		in_clear = 1'b0;
		out_clear = 1'b0;

		test_mode = st.sim | st.seq;
		next_st.sync = {st.sync[0], MANUAL_FIRE_SOFTKEY_IN_I};

		// Input pulse qualification
		// Waiting for the pin to drop makes a held pin fire only once
		in_target = (st.in_width == 6'h00) ? IN_WIDTH_DFLT : clamp_width(st.in_width);
		unique case (st.qual)
			Q_IDLE: begin
				in_clear = 1'b1;
				next_st.in_ms = '0;
				if (st.sync[1]) begin
					next_st.qual = Q_MEASURE;
				end
			end
			Q_MEASURE: begin
				if (!st.sync[1]) begin
					next_st.qual = Q_IDLE;
				end else if (in_tick) begin
					next_st.in_ms = st.in_ms + 6'h01;
					if (st.in_ms + 6'h01 >= in_target) begin
						fire = 1'b1;
						next_st.qual = Q_WAIT_LOW;
					end
				end
			end
			Q_WAIT_LOW: begin
				if (!st.sync[1]) begin
					next_st.qual = Q_IDLE;
				end
			end
		endcase

		// Pin actions, blocked in the test modes
		// Unused action codes behave like none
		if (fire && !test_mode) begin
			unique case (st.action)
				ACT_OUTPUT: next_st.out_en = st.status;
				ACT_SETTING: begin
					next_st.act_v = st.user_v;
					next_st.act_f = st.user_f;
				end
				ACT_PRESET: begin
					if (slot_ok(st.index)) begin
						next_st.act_v = st.pre_v[st.index];
						next_st.act_f = st.pre_f[st.index];
						next_st.load_ev = 1'b1;
					end
				end
				ACT_TRANS: next_st.trans = 1'b1;
				default: ;
			endcase
		end

		// Register writes
		// Writes follow pin actions, so software wins a same-cycle clash
		if (WR_I) begin
			unique case (ADDR_I)
				REG_IN_CFG: begin
					next_st.action = WDATA_I[F_ACTION +: 3];
					next_st.in_width = WDATA_I[F_WIDTH +: 6];
					next_st.status = WDATA_I[F_STATUS];
					next_st.index = WDATA_I[F_INDEX +: 4];
				end
				REG_OUT_CFG: begin
					next_st.source = WDATA_I[F_ACTION +: 3];
					next_st.out_width = WDATA_I[F_WIDTH +: 6];
					next_st.level = WDATA_I[F_LEVEL];
				end
				REG_USER_V: next_st.user_v = WDATA_I[VW-1:0];
				REG_USER_F: next_st.user_f = WDATA_I[VW-1:0];
				REG_OUT_CTL: next_st.out_en = WDATA_I[0];
				REG_ACT_V: next_st.act_v = WDATA_I[VW-1:0];
				REG_ACT_F: next_st.act_f = WDATA_I[VW-1:0];
				REG_MODE: begin
					next_st.sim = WDATA_I[F_MODE_SIM];
					next_st.seq = WDATA_I[F_MODE_SEQ];
				end
				REG_CMD: wr_cmd = 1'b1;
				default: ;
			endcase
		end

		// Remote commands work whatever the pin setup says
		// Save wins over load when both bits are set
		cmd_slot = WDATA_I[C_SLOT +: 4];
		if (wr_cmd) begin
			if (WDATA_I[C_TRANS]) begin
				next_st.trans = 1'b1;
			end
			if (WDATA_I[C_SAVE] && slot_ok(cmd_slot)) begin
				next_st.pre_v[cmd_slot] = st.act_v;
				next_st.pre_f[cmd_slot] = st.act_f;
				next_st.save_ev = 1'b1;
			end else if (WDATA_I[C_LOAD] && slot_ok(cmd_slot)) begin
				next_st.act_v = st.pre_v[cmd_slot];
				next_st.act_f = st.pre_f[cmd_slot];
				next_st.load_ev = 1'b1;
			end
		end

		// Output source events
		// Next state is compared with present, so rewriting equal data is silent
		ev_out = (next_st.out_en != st.out_en);
		ev_set = (next_st.act_v != st.act_v) || (next_st.act_f != st.act_f);
		ev_pre = next_st.load_ev | next_st.save_ev;
		if (!test_mode) begin
			unique case (st.source)
				SRC_OUTPUT: activate = ev_out;
				SRC_SETTING: activate = ev_set;
				SRC_PRESET: activate = ev_pre;
				SRC_ALL: activate = ev_out | ev_set | ev_pre;
				default: activate = 1'b0;
			endcase
		end
		if (wr_cmd && WDATA_I[C_OUTTRG]) begin
			activate = 1'b1;
		end

		// Condition flag: a new event wins over a clear in the same cycle
		next_st.cond = (st.cond & ~(wr_cmd & WDATA_I[C_CLRCOND])) | activate;

		// Output pin
		// A retrigger restarts the count: close events merge into one long pulse
		ow = clamp_width(st.out_width);
		if (ow == 6'h00) begin
			next_st.pst = P_IDLE;
			next_st.out_ms = '0;
			next_st.pin = next_st.cond ? st.level : ~st.level;
		end else begin
			unique case (st.pst)
				P_IDLE: begin
					next_st.pin = 1'b0;
					if (activate) begin
						out_clear = 1'b1;
						next_st.out_ms = '0;
						next_st.pst = P_PULSE;
						next_st.pin = 1'b1;
					end
				end
				P_PULSE: begin
					if (activate) begin
						out_clear = 1'b1;
						next_st.out_ms = '0;
					end else if (out_tick) begin
						next_st.out_ms = st.out_ms + 6'h01;
						if (st.out_ms + 6'h01 >= ow) begin
							next_st.pst = P_IDLE;
							next_st.pin = 1'b0;
						end
					end
				end
			endcase
		end

		// Read data, valid only in the cycle after the strobe
		next_st.rdata = '0;
		if (RD_I) begin
			unique case (ADDR_I)
				REG_IN_CFG: begin
					next_st.rdata[F_ACTION +: 3] = st.action;
					next_st.rdata[F_WIDTH +: 6] = st.in_width;
					next_st.rdata[F_STATUS] = st.status;
					next_st.rdata[F_INDEX +: 4] = st.index;
				end
				REG_OUT_CFG: begin
					next_st.rdata[F_ACTION +: 3] = st.source;
					next_st.rdata[F_WIDTH +: 6] = st.out_width;
					next_st.rdata[F_LEVEL] = st.level;
				end
				REG_USER_V: next_st.rdata[VW-1:0] = st.user_v;
				REG_USER_F: next_st.rdata[VW-1:0] = st.user_f;
				REG_OUT_CTL: next_st.rdata[0] = st.out_en;
				REG_ACT_V: next_st.rdata[VW-1:0] = st.act_v;
				REG_ACT_F: next_st.rdata[VW-1:0] = st.act_f;
				REG_MODE: begin
					next_st.rdata[F_MODE_SIM] = st.sim;
					next_st.rdata[F_MODE_SEQ] = st.seq;
				end
				REG_STATUS: begin
					next_st.rdata[0] = st.pin;
					next_st.rdata[1] = st.cond;
					next_st.rdata[2] = st.sync[1];
					next_st.rdata[3] = (st.qual != Q_IDLE);
				end
				default: next_st.rdata = '0;
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Reset clears every field, the preset slots included
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA_O = st.rdata;
	assign MANUAL_FIRE_SOFTKEY_OUT_O = st.pin;
	assign OUTPUT_EN_O = st.out_en;
	assign VOLT_O = st.act_v;
	assign FREQ_O = st.act_f;
	assign TRANSIENT_START_O = st.trans;
	assign PRESET_LOAD_O = st.load_ev;
	assign PRESET_SAVE_O = st.save_ev;

endmodule : manual_fire_softkey_io_ctrl
`default_nettype wire

// >>> bench/manual_fire_softkey_io_sva.sv
// Assertion checker for the trigger pin controller
`timescale 1ns/1ps
`default_nettype none
module manual_fire_softkey_io_sva #(
	parameter int unsigned MS_CYC = 20000
) (
	input wire logic                       REF_CLK_I,
	input wire logic                       NRST_I,
	input wire logic                       MANUAL_FIRE_SOFTKEY_IN_I,
	input wire logic [manual_fire_softkey_io_pkg::AW-1:0] ADDR_I,
	input wire logic [manual_fire_softkey_io_pkg::DW-1:0] WDATA_I,
	input wire logic                       WR_I,
	input wire logic                       RD_I,
	input wire logic [manual_fire_softkey_io_pkg::DW-1:0] RDATA_O,
	input wire logic                       MANUAL_FIRE_SOFTKEY_OUT_O,
	input wire logic                       OUTPUT_EN_O,
	input wire logic [manual_fire_softkey_io_pkg::VW-1:0] VOLT_O,
	input wire logic [manual_fire_softkey_io_pkg::VW-1:0] FREQ_O,
	input wire logic                       TRANSIENT_START_O,
	input wire logic                       PRESET_LOAD_O,
	input wire logic                       PRESET_SAVE_O
);
	import manual_fire_softkey_io_pkg::*;
	// ****************
	// Config shadow
	// ****************
	logic [2:0] src;
	logic [5:0] ow;
	logic [5:0] iw;
	logic [1:0] md;
	logic       tin_q;
	int         run;
	int         need;
	always_comb need = ((iw == 6'h00) ? 5 : ((iw > WIDTH_MAX) ? 60 : int'(iw))) * MS_CYC;
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			src <= '0;
			ow <= '0;
			iw <= '0;
			md <= '0;
			tin_q <= 1'b0;
			run <= 0;
		end else begin
			tin_q <= MANUAL_FIRE_SOFTKEY_IN_I;
			if (MANUAL_FIRE_SOFTKEY_IN_I) run <= tin_q ? run + 1 : 1;
			if (WR_I && ADDR_I == REG_OUT_CFG) src <= WDATA_I[2:0];
			if (WR_I && ADDR_I == REG_OUT_CFG) ow <= WDATA_I[8:3];
			if (WR_I && ADDR_I == REG_IN_CFG) iw <= WDATA_I[8:3];
			if (WR_I && ADDR_I == REG_MODE) md <= WDATA_I[1:0];
		end
	end
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
		else $error("Read data not idle");
	start_pulse_a: assert property (TRANSIENT_START_O |=> !TRANSIENT_START_O)
		else $error("Start pulse too long");
	load_save_a: assert property (PRESET_LOAD_O |-> !PRESET_SAVE_O ##1 !PRESET_LOAD_O)
		else $error("Load pulse wrong");
	out_fire_a: assert property (
		$changed(OUTPUT_EN_O) && src == SRC_OUTPUT && ow != '0 |-> ##[0:2] MANUAL_FIRE_SOFTKEY_OUT_O)
		else $error("No pin pulse on enable change");
	set_fire_a: assert property (
		($changed(VOLT_O) || $changed(FREQ_O)) && src == SRC_SETTING && ow != '0
		|-> ##[0:2] MANUAL_FIRE_SOFTKEY_OUT_O) else $error("No pin pulse on setting change");
	preset_fire_a: assert property (
		(PRESET_LOAD_O || PRESET_SAVE_O) && src == SRC_PRESET && ow != '0
		|-> ##[0:2] MANUAL_FIRE_SOFTKEY_OUT_O) else $error("No pin pulse on preset");
	all_fire_a: assert property (
		($changed(OUTPUT_EN_O) || $changed(VOLT_O) || PRESET_SAVE_O) && src == SRC_ALL
		&& ow != '0 |-> ##[0:2] MANUAL_FIRE_SOFTKEY_OUT_O) else $error("No pin pulse in all mode");
	// Bench runs MS_CYC of 4, so one ms is at least four cycles
	pulse_min_a: assert property ($rose(MANUAL_FIRE_SOFTKEY_OUT_O) && ow != '0 |-> MANUAL_FIRE_SOFTKEY_OUT_O[*4])
		else $error("Pin pulse too short");
	pin_width_a: assert property (
		(TRANSIENT_START_O || PRESET_LOAD_O) && !$past(WR_I) |-> run >= need)
		else $error("Action from short pulse");
	mode_block_a: assert property (
		TRANSIENT_START_O && !$past(WR_I) |-> md == 2'h0) else $error("Action in test mode");
	cover property (TRANSIENT_START_O && !$past(WR_I));
	cover property (PRESET_LOAD_O);
	cover property ($fell(MANUAL_FIRE_SOFTKEY_OUT_O) && ow != '0);
endmodule : manual_fire_softkey_io_sva
bind manual_fire_softkey_io_ctrl manual_fire_softkey_io_sva #(.MS_CYC(MS_CYC)) u_sva (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
	.MANUAL_FIRE_SOFTKEY_IN_I(MANUAL_FIRE_SOFTKEY_IN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
	.RDATA_O(RDATA_O), .MANUAL_FIRE_SOFTKEY_OUT_O(MANUAL_FIRE_SOFTKEY_OUT_O), .OUTPUT_EN_O(OUTPUT_EN_O), .VOLT_O(VOLT_O),
	.FREQ_O(FREQ_O), .TRANSIENT_START_O(TRANSIENT_START_O), .PRESET_LOAD_O(PRESET_LOAD_O),
	.PRESET_SAVE_O(PRESET_SAVE_O));
`default_nettype wire

// >>> bench/manual_fire_softkey_equip.sv
// Model of the equipment wired to the trigger connector
`timescale 1ns/1ps
`default_nettype none
module manual_fire_softkey_equip (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] len_i,
	input  wire logic       manual_fire_softkey_out_i,
	output logic            manual_fire_softkey_o = 1'b0,
	output int              pulses_o = 0,
	output int              last_w_o = 0
);
	int   left = 0;
	int   hi = 0;
	logic q = 1'b0;
	// Pulse of len_i cycles; length decides acceptance
	always @(posedge clk_i) begin
		q <= manual_fire_softkey_out_i;
		left <= go_i ? int'(len_i) : ((left > 0) ? left - 1 : 0);
		manual_fire_softkey_o <= go_i || left > 1;
		if (manual_fire_softkey_out_i) hi <= q ? hi + 1 : 1;
		if (manual_fire_softkey_out_i && !q) pulses_o <= pulses_o + 1;
		if (!manual_fire_softkey_out_i && q) last_w_o <= hi;
	end
endmodule : manual_fire_softkey_equip
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench for the trigger pin controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import manual_fire_softkey_io_pkg::*;
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic          go = 1'b0;
	logic          tin;
	logic [7:0]    len = 8'h00;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic [DW-1:0] rdata;
	logic          tout;
	logic          oen;
	logic          tst;
	logic          pld;
	logic          psv;
	logic [VW-1:0] volt;
	logic [VW-1:0] freq;
	int            fail_count = 0;
	int            checks_done = 0;
	int            cyc = 0;
	int            n_st = 0;
	int            n_ld = 0;
	int            n_sv = 0;
	int            pulses;
	int            last_w;
	int            p0;
	// Short ms so each case takes tens of cycles
	manual_fire_softkey_io_ctrl #(.MS_CYC(4)) DUT (.REF_CLK_I(clk), .NRST_I(nrst), .MANUAL_FIRE_SOFTKEY_IN_I(tin),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.MANUAL_FIRE_SOFTKEY_OUT_O(tout), .OUTPUT_EN_O(oen), .VOLT_O(volt), .FREQ_O(freq),
		.TRANSIENT_START_O(tst), .PRESET_LOAD_O(pld), .PRESET_SAVE_O(psv));
	manual_fire_softkey_equip u_equip (.clk_i(clk), .go_i(go), .len_i(len), .manual_fire_softkey_out_i(tout), .manual_fire_softkey_o(tin),
		.pulses_o(pulses), .last_w_o(last_w));
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		n_st <= n_st + int'(tst);
		n_ld <= n_ld + int'(pld);
		n_sv <= n_sv + int'(psv);
		if (cyc == 5000) begin
			fail_count++;
			stop_test();
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic stop_test();
		if (fail_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : pause
	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		pause(1);
	endtask : wr_reg
	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
		pause(1);
	endtask : rd_chk
	task automatic pin(input logic [7:0] l);
		len <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		pause(int'(l) + 24);
	endtask : pin
	// ****************
	// Sequence
	// ****************
	initial begin
		pause(3);
		nrst <= 1'b1;
		pause(1);
		chk("idle pin", 1, tout);
		wr_reg(REG_OUT_CFG, 32'h219 | SRC_OUTPUT);
		rd_chk(REG_OUT_CFG, 32'h219);
		rd_chk(8'h30, 32'h0);
		p0 = pulses;
		wr_reg(REG_IN_CFG, 32'h210 | ACT_OUTPUT);
		pin(8'h06);
		chk("short pulse", 0, oen);
		pin(8'h0a);
		chk("enable on", 1, oen);
		chk("pin pulses", p0 + 1, pulses);
		chk("pin width", 12, last_w);
		wr_reg(REG_IN_CFG, 32'h010 | ACT_OUTPUT);
		pin(8'h0a);
		chk("enable off", 0, oen);
		chk("pin pulses", p0 + 2, pulses);
		wr_reg(REG_OUT_CFG, 32'h018 | SRC_NONE);
		wr_reg(REG_OUT_CTL, 32'h1);
		pause(20);
		chk("none src", p0 + 2, pulses);
		wr_reg(REG_CMD, 32'h2);
		pause(20);
		chk("remote out", p0 + 3, pulses);
		wr_reg(REG_OUT_CFG, 32'h008 | SRC_SETTING);
		wr_reg(REG_USER_V, 32'h0123);
		wr_reg(REG_USER_F, 32'h003c);
		wr_reg(REG_IN_CFG, 32'h008 | ACT_SETTING);
		pin(8'h07);
		chk("volt", 16'h0123, volt);
		chk("freq", 16'h003c, freq);
		chk("set pulse", p0 + 4, pulses);
		chk("width 1", 4, last_w);
		wr_reg(REG_OUT_CFG, 32'h008 | SRC_PRESET);
		wr_reg(REG_ACT_V, 32'h0abc);
		wr_reg(REG_CMD, 32'h904);
		pause(20);
		chk("save pulse", p0 + 5, pulses);
		chk("saves", 1, n_sv);
		wr_reg(REG_ACT_V, 32'h0);
		wr_reg(REG_IN_CFG, 32'h2408 | ACT_PRESET);
		pin(8'h07);
		chk("slot 9", 16'h0abc, volt);
		chk("loads", 1, n_ld);
		chk("load pulse", p0 + 6, pulses);
		wr_reg(REG_IN_CFG, 32'h008 | ACT_NONE);
		pin(8'h07);
		chk("none act", 0, n_st);
		chk("none oen", 1, oen);
		wr_reg(REG_CMD, 32'h1);
		pause(2);
		chk("remote start", 1, n_st);
		wr_reg(REG_IN_CFG, 32'h0 | ACT_TRANS);
		pin(8'h11);
		chk("below 5ms", 1, n_st);
		pin(8'h18);
		chk("start", 2, n_st);
		wr_reg(REG_MODE, 32'h1);
		pin(8'h18);
		wr_reg(REG_MODE, 32'h2);
		pin(8'h18);
		chk("test modes", 2, n_st);
		wr_reg(REG_MODE, 32'h0);
		// Gaps keep pulses apart; a retrigger would merge them
		wr_reg(REG_OUT_CFG, 32'h008 | SRC_ALL);
		wr_reg(REG_OUT_CTL, 32'h0);
		pause(12);
		wr_reg(REG_ACT_F, 32'h0032);
		pause(12);
		wr_reg(REG_CMD, 32'h004);
		pause(12);
		chk("all src", p0 + 9, pulses);
		wr_reg(REG_OUT_CFG, 32'h200 | SRC_NONE);
		wr_reg(REG_CMD, 32'h10);
		chk("level low", 0, tout);
		wr_reg(REG_CMD, 32'h2);
		pause(10);
		chk("level held", 1, tout);
		wr_reg(REG_OUT_CFG, 32'h0 | SRC_NONE);
		pause(1);
		chk("level inv", 0, tout);
		rd_chk(REG_STATUS, 32'h2);
		wr_reg(REG_CMD, 32'h908);
		chk("remote load", 16'h003c, freq);
		chk("remote loads", 2, n_ld);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
